// ==== rtl/ddr3_ca_params.svh ====
// constants for the x16 ddr3 command/address pin front end
`ifndef DDR3_CA_PARAMS_SVH
`define DDR3_CA_PARAMS_SVH
`define ROW_BITS 13
`define BANK_BITS 3
`define BANKS 8
`define AP_BIT 10
`define BC_BIT 12
`define MR_COUNT 4
`define MR1_RTT_NOM_MASK 16'h0244
`define MR2_RTT_WR_MASK 16'h0600
`define MR_RESET 16'h0000
`define CMD_MRS 3'h0
`define CMD_REF 3'h1
`define CMD_PRE 3'h2
`define CMD_ACT 3'h3
`define CMD_WR 3'h4
`define CMD_RD 3'h5
`define CMD_ZQ 3'h6
`define CMD_NOP 3'h7
`define MR1_INDEX 2'h1
`define MR2_INDEX 2'h2
`define LANES 2
`endif

// ==== rtl/ddr3_ca_pkg.sv ====
// types shared by the ddr3 command/address front end
package ddr3_ca_pkg;
    typedef enum logic [2:0] {
        op_mrs, op_ref, op_pre, op_act, op_wr, op_rd, op_zq, op_nop
    } op_t;
    typedef enum {
        st_idle, st_pd_pre, st_pd_act, st_self_ref
    } power_t;
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] bank;
        logic [12:0] addr;
    } ca_t;
    typedef struct packed {
        logic valid;
        op_t op;
        logic [2:0] bank;
        logic [12:0] addr;
        logic auto_pre;
        logic all_banks;
        logic chop;
    } cmd_t;
endpackage : ddr3_ca_pkg

// ==== rtl/ddr3_cmd_decode.sv ====
// command truth table decode of one registered ca word
`include "ddr3_ca_params.svh"
module ddr3_cmd_decode (
    // registered pins
    input wire ddr3_ca_pkg::ca_t ca,
    // decoded command
    output ddr3_ca_pkg::cmd_t cmd
);
    always_comb begin
        cmd = '0;
        cmd.bank = ca.bank;
        cmd.addr = ca.addr;
        cmd.op = ddr3_ca_pkg::op_t'({ca.ras_n, ca.cas_n, ca.we_n});
        cmd.valid = !ca.cs_n && cmd.op != ddr3_ca_pkg::op_nop;
        cmd.auto_pre = ca.addr[`AP_BIT];
        cmd.all_banks = ca.addr[`AP_BIT];
        cmd.chop = !ca.addr[`BC_BIT];
    end
endmodule : ddr3_cmd_decode

// ==== rtl/ddr3_mode_regs.sv ====
// mode register file; read data comes out of a register
`include "ddr3_ca_params.svh"
module ddr3_mode_regs #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // write port
    input wire logic wr_en,
    input wire logic [1:0] wr_sel,
    input wire logic [WIDTH-1:0] wr_data,
    // read port
    input wire logic [1:0] rd_sel,
    output logic [WIDTH-1:0] rd_data,
    output logic [WIDTH-1:0] mr1,
    output logic [WIDTH-1:0] mr2
);
    logic [WIDTH-1:0] mem [`MR_COUNT];
    logic [WIDTH-1:0] next_mem [`MR_COUNT];
    logic [WIDTH-1:0] next_rd_data;
    always_comb begin
        for (int i = 0; i < `MR_COUNT; i++) begin
            next_mem[i] = mem[i];
        end
        if (wr_en) begin
            next_mem[wr_sel] = wr_data;
        end
        next_rd_data = mem[rd_sel];
    end
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < `MR_COUNT; i++) begin
            mem[i] <= rst ? `MR_RESET : next_mem[i];
        end
        rd_data <= rst ? `MR_RESET : next_rd_data;
    end
    assign mr1 = mem[`MR1_INDEX];
    assign mr2 = mem[`MR2_INDEX];
endmodule : ddr3_mode_regs

// ==== rtl/ddr3_ca_frontend.sv ====
// ddr3 x16 command/address/control pin front end, device side
`include "ddr3_ca_params.svh"
module ddr3_ca_frontend #(
    parameter int ROWS = `ROW_BITS,
    parameter int BANKS = `BANKS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // pins from the controller
    input wire logic reset_n,
    input wire logic cke,
    input wire ddr3_ca_pkg::ca_t ca_pins,
    input wire logic odt,
    // write data beats, one per strobe edge, with per-lane mask
    input wire logic wr_beat,
    input wire logic [15:0] wr_dq,
    input wire logic [`LANES-1:0] wr_dm,
    // decoded command out
    output ddr3_ca_pkg::cmd_t cmd,
    output logic [ROWS-1:0] row_addr,
    output logic [ROWS-1:0] col_addr,
    // write data accepted into the array
    output logic [15:0] store_data,
    output logic [`LANES-1:0] store_lane_en,
    // device state
    output logic clocks_on,
    output logic pd_buffers_on,
    output logic sr_active,
    output logic active_pd,
    output logic term_on,
    output logic [BANKS-1:0] bank_open,
    output logic [15:0] mr_rd_data,
    output logic in_reset
);
    // reset pin and cke come from the pins: two stages each
    logic rst_sync1, rst_sync2, cke_sync1, cke_sync2;
    logic odt_q, cke_q;
    ddr3_ca_pkg::ca_t ca_q;
    ddr3_ca_pkg::cmd_t dec;
    ddr3_ca_pkg::power_t pstate, next_pstate;
    logic [BANKS-1:0] next_bank_open;
    logic dev_rst;
    logic buf_on;
    logic [15:0] mr1, mr2;
    logic mrs_we;
    logic [ROWS-1:0] next_row, next_col;
    ddr3_ca_pkg::cmd_t next_cmd;
    logic [15:0] next_store;
    logic [`LANES-1:0] next_lane;
    logic next_term;
    // refresh word is decoded one edge before the synchronised cke fall shows up
    logic ref_q, next_ref;
    localparam ddr3_ca_pkg::ca_t CA_IDLE = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
        default: '0};

    always_ff @(posedge clk_sys) begin
        rst_sync1 <= rst ? 1'b0 : reset_n;
        rst_sync2 <= rst ? 1'b0 : rst_sync1;
        cke_sync1 <= rst ? 1'b0 : cke;
        cke_sync2 <= rst ? 1'b0 : cke_sync1;
    end
    // reset held until the pin has passed both stages high
    assign dev_rst = rst || !rst_sync2;

    // command pins pass buffers only while clocks run and not in power-down/self-refresh
    assign buf_on = cke_q && pstate == ddr3_ca_pkg::st_idle;

    always_ff @(posedge clk_sys) begin
        if (dev_rst) begin
            ca_q <= CA_IDLE;
            odt_q <= 1'b0;
            cke_q <= 1'b0;
        end else begin
            // chip select forced high while buffers are off, so nothing decodes
            ca_q <= buf_on ? ca_pins : CA_IDLE;
            // termination buffer stays alive in power-down but not self-refresh
            odt_q <= (pstate == ddr3_ca_pkg::st_self_ref) ? 1'b0 : odt;
            cke_q <= cke_sync2;
        end
    end

    ddr3_cmd_decode u_dec (
        .ca(ca_q),
        .cmd(dec)
    );

    assign mrs_we = dec.valid && dec.op == ddr3_ca_pkg::op_mrs;
    ddr3_mode_regs #(
        .WIDTH(16)
    ) u_mr (
        .clk_sys(clk_sys),
        .rst(dev_rst),
        .wr_en(mrs_we),
        .wr_sel(dec.bank[1:0]),
        .wr_data({3'h0, dec.addr}),
        .rd_sel(dec.bank[1:0]),
        .rd_data(mr_rd_data),
        .mr1(mr1),
        .mr2(mr2)
    );

    // bank state and power state
    always_comb begin
        next_bank_open = bank_open;
        next_pstate = pstate;
        // held one cycle so a refresh sent with cke low meets the late synchronised fall
        next_ref = dec.valid && dec.op == ddr3_ca_pkg::op_ref;
        if (dec.valid) begin
            unique case (dec.op)
                ddr3_ca_pkg::op_act: next_bank_open[dec.bank] = 1'b1;
                ddr3_ca_pkg::op_pre: begin
                    if (dec.all_banks) begin
                        next_bank_open = '0;
                    end else begin
                        next_bank_open[dec.bank] = 1'b0;
                    end
                end
                ddr3_ca_pkg::op_rd, ddr3_ca_pkg::op_wr: begin
                    if (dec.auto_pre) begin
                        next_bank_open[dec.bank] = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        unique case (pstate)
            ddr3_ca_pkg::st_idle: begin
                // cke low with refresh on the same edge enters self-refresh when all banks are closed
                if (!cke_sync2 && cke_q) begin
                    if (ref_q && bank_open == '0) begin
                        next_pstate = ddr3_ca_pkg::st_self_ref;
                    end else if (bank_open == '0) begin
                        next_pstate = ddr3_ca_pkg::st_pd_pre;
                    end else begin
                        next_pstate = ddr3_ca_pkg::st_pd_act;
                    end
                end
            end
            ddr3_ca_pkg::st_pd_pre, ddr3_ca_pkg::st_pd_act: begin
                if (cke_sync2) begin
                    next_pstate = ddr3_ca_pkg::st_idle;
                end
            end
            ddr3_ca_pkg::st_self_ref: begin
                // exit taken straight off the synchronised cke level, no command clock needed
                if (cke_sync2) begin
                    next_pstate = ddr3_ca_pkg::st_idle;
                end
            end
        endcase
    end

    // outputs registered
    always_comb begin
        next_cmd = dec;
        next_row = (dec.valid && dec.op == ddr3_ca_pkg::op_act) ? dec.addr : row_addr;
        next_col = (dec.valid && (dec.op == ddr3_ca_pkg::op_rd || dec.op == ddr3_ca_pkg::op_wr))
            ? dec.addr : col_addr;
        // enabled with odt outside self-refresh unless mode registers both zero the termination fields
        next_term = odt_q && pstate != ddr3_ca_pkg::st_self_ref
            && ((mr1 & `MR1_RTT_NOM_MASK) != '0 || (mr2 & `MR2_RTT_WR_MASK) != '0);
        next_store = wr_dq;
        // controller keeps cke high over writes, so beats only land with clocks on
        next_lane = '0;
        for (int i = 0; i < `LANES; i++) begin
            next_lane[i] = wr_beat && cke_q && !wr_dm[i];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (dev_rst) begin
            pstate <= ddr3_ca_pkg::st_idle;
            ref_q <= 1'b0;
            bank_open <= '0;
            cmd <= '0;
            row_addr <= '0;
            col_addr <= '0;
            term_on <= 1'b0;
            store_data <= '0;
            store_lane_en <= '0;
        end else begin
            pstate <= next_pstate;
            ref_q <= next_ref;
            bank_open <= next_bank_open;
            cmd <= next_cmd;
            row_addr <= next_row;
            col_addr <= next_col;
            term_on <= next_term;
            store_data <= next_store;
            store_lane_en <= next_lane;
        end
    end

    assign clocks_on = cke_q;
    assign pd_buffers_on = buf_on;
    assign sr_active = pstate == ddr3_ca_pkg::st_self_ref;
    assign active_pd = pstate == ddr3_ca_pkg::st_pd_act;
    assign in_reset = dev_rst;
endmodule : ddr3_ca_frontend

// ==== testbench/ddr3_ca_checker_properties.sv ====
// assertion checker for the ddr3 command/address front end
module ddr3_ca_checker #(
    parameter int ROWS = 13,
    parameter int BANKS = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // watched pins and outputs
    input wire logic wr_beat,
    input wire logic [1:0] wr_dm,
    input wire ddr3_ca_pkg::ca_t ca_pins,
    input wire ddr3_ca_pkg::cmd_t cmd,
    input wire logic [ROWS-1:0] row_addr,
    input wire logic [1:0] store_lane_en,
    input wire logic sr_active,
    input wire logic term_on,
    input wire logic [BANKS-1:0] bank_open,
    input wire logic in_reset
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // pin word as seen two edges back, lined up with cmd
    ddr3_ca_pkg::ca_t ca_d1, ca_d2;
    always_ff @(posedge clk_sys) begin
        ca_d1 <= ca_pins;
        ca_d2 <= ca_d1;
    end
    property p_mask;
        cmd.valid |-> !ca_d2.cs_n;
    endproperty
    a_mask: assert property (p_mask) else $error("command from deselected cycle");
    property p_op;
        cmd.valid |-> cmd.op == {ca_d2.ras_n, ca_d2.cas_n, ca_d2.we_n};
    endproperty
    a_op: assert property (p_op) else $error("wrong command decode");
    property p_bank;
        cmd.valid |-> cmd.bank == ca_d2.bank;
    endproperty
    a_bank: assert property (p_bank) else $error("wrong bank");
    property p_rw;
        cmd.valid && cmd.op[2:1] == 2'h2
            |-> cmd.auto_pre == ca_d2.addr[10] && cmd.chop == !ca_d2.addr[12];
    endproperty
    a_rw: assert property (p_rw) else $error("wrong precharge or chop flag");
    property p_act;
        cmd.valid && cmd.op == ddr3_ca_pkg::op_act
            |-> row_addr == ca_d2.addr && bank_open[ca_d2.bank];
    endproperty
    a_act: assert property (p_act) else $error("activate row not taken");
    property p_sr;
        sr_active && $past(sr_active) |-> !term_on;
    endproperty
    a_sr: assert property (p_sr) else $error("termination on in self-refresh");
    property p_lane;
        |store_lane_en |-> $past(wr_beat) && !(|(store_lane_en & $past(wr_dm)));
    endproperty
    a_lane: assert property (p_lane) else $error("masked lane stored");
    property p_reset;
        in_reset |=> bank_open == '0 && !cmd.valid;
    endproperty
    a_reset: assert property (p_reset) else $error("state kept in reset");
endmodule : ddr3_ca_checker

bind ddr3_ca_frontend ddr3_ca_checker #(.ROWS(ROWS), .BANKS(BANKS)) u_ddr3_ca_checker (
    .clk_sys(clk_sys), .rst(rst), .wr_beat(wr_beat), .wr_dm(wr_dm), .ca_pins(ca_pins),
    .cmd(cmd), .row_addr(row_addr), .store_lane_en(store_lane_en), .sr_active(sr_active),
    .term_on(term_on), .bank_open(bank_open), .in_reset(in_reset));

// ==== testbench/ddr3_host_model.sv ====
// host controller model driving the command/address pins
module ddr3_host_model (
    // pins toward the device
    output ddr3_ca_pkg::ca_t ca_pins,
    output logic cke,
    output logic odt,
    output logic reset_n,
    // clock
    input wire logic clk_sys
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        ca_pins = '1;
        cke = 1'b1;
        odt = 1'b0;
        reset_n = 1'b1;
    end
    // cke untouched here, so it stays high across reads and writes
    task automatic issue(input logic cs, input logic [2:0] code, input logic [2:0] bank,
                         input logic [12:0] addr);
        @(negedge clk_sys);
        ca_pins = {cs, code, bank, addr};
        @(negedge clk_sys);
        // inverted leftovers so a late sample never repeats the word
        ca_pins = {1'b1, 3'h7, ~bank, ~addr};
    endtask : issue
    task automatic park(input logic [2:0] bank);
        @(negedge clk_sys);
        ca_pins = {1'b1, 3'h7, bank, 13'h0000};
    endtask : park
    task automatic pins(input logic c, input logic o, input logic r);
        @(negedge clk_sys);
        cke = c;
        odt = o;
        reset_n = r;
    endtask : pins
    // refresh word with cke dropped alongside it
    task automatic sr_enter();
        @(negedge clk_sys);
        ca_pins = {1'b0, 3'h1, 3'h0, 13'h0000};
        cke = 1'b0;
        @(negedge clk_sys);
        ca_pins = '1;
    endtask : sr_enter
endmodule : ddr3_host_model

// ==== testbench/test_ddr3_ca_frontend.sv ====
// self-checking bench for the ddr3 command/address front end
`include "ddr3_ca_params.svh"
module test_ddr3_ca_frontend;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic wr_beat = 1'b0;
    logic [15:0] wr_dq = 16'h0000;
    logic [1:0] wr_dm = 2'h0;
    ddr3_ca_pkg::ca_t ca_pins;
    ddr3_ca_pkg::cmd_t cmd;
    logic cke, odt, reset_n, clocks_on, pd_buffers_on, sr_active, active_pd, term_on, in_reset;
    logic [12:0] row_addr, col_addr;
    logic [15:0] store_data, mr_rd_data;
    logic [1:0] store_lane_en;
    logic [7:0] bank_open;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    ddr3_host_model u_ddr3_host_model (.ca_pins(ca_pins), .cke(cke), .odt(odt),
        .reset_n(reset_n), .clk_sys(clk_sys));
    ddr3_ca_frontend u_ddr3_ca_frontend (.clk_sys(clk_sys), .rst(rst), .reset_n(reset_n),
        .cke(cke), .ca_pins(ca_pins), .odt(odt), .wr_beat(wr_beat), .wr_dq(wr_dq),
        .wr_dm(wr_dm), .cmd(cmd), .row_addr(row_addr), .col_addr(col_addr),
        .store_data(store_data), .store_lane_en(store_lane_en), .clocks_on(clocks_on),
        .pd_buffers_on(pd_buffers_on), .sr_active(sr_active), .active_pd(active_pd),
        .term_on(term_on), .bank_open(bank_open), .mr_rd_data(mr_rd_data),
        .in_reset(in_reset));
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    // bounded wait for the one-cycle command pulse
    task automatic wait_cmd();
        for (int i = 0; i < 6 && cmd.valid !== 1'b1; i++) begin
            tick(1);
        end
    endtask : wait_cmd
    task automatic t_act_rw();
        u_ddr3_host_model.issue(1'b0, `CMD_ACT, 3'h3, 13'h1ABC);
        wait_cmd();
        check(cmd.op, ddr3_ca_pkg::op_act);
        check(row_addr, 13'h1ABC);
        check(bank_open[3], 1'b1);
        u_ddr3_host_model.issue(1'b0, `CMD_WR, 3'h3, 13'h0408);
        wait_cmd();
        check({cmd.auto_pre, cmd.chop}, 2'h3);
        check(col_addr, 13'h0408);
        u_ddr3_host_model.issue(1'b0, `CMD_RD, 3'h3, 13'h1010);
        wait_cmd();
        check({cmd.op, cmd.auto_pre, cmd.chop}, {ddr3_ca_pkg::op_rd, 2'h0});
    endtask : t_act_rw
    task automatic t_mask();
        u_ddr3_host_model.issue(1'b1, `CMD_ACT, 3'h5, 13'h0011);
        wait_cmd();
        check({cmd.valid, bank_open[5]}, 2'h0);
    endtask : t_mask
    task automatic t_beat();
        @(negedge clk_sys);
        {wr_beat, wr_dq, wr_dm} = {1'b1, 16'hA55A, 2'h1};
        @(negedge clk_sys);
        check({store_lane_en, store_data[15:8]}, {2'h2, 8'hA5});
        {wr_dq, wr_dm} = {16'h3CC3, 2'h2};
        @(negedge clk_sys);
        check({store_lane_en, store_data[7:0]}, {2'h1, 8'hC3});
        wr_beat = 1'b0;
    endtask : t_beat
    task automatic t_mode_term();
        u_ddr3_host_model.pins(1'b1, 1'b1, 1'b1);
        tick(4);
        check(term_on, 1'b0);
        u_ddr3_host_model.issue(1'b0, `CMD_MRS, 3'h1, 13'h0004);
        u_ddr3_host_model.park(3'h1);
        tick(4);
        check(mr_rd_data, 16'h0004);
        check(term_on, 1'b1);
    endtask : t_mode_term
    task automatic t_pd();
        u_ddr3_host_model.issue(1'b0, `CMD_ACT, 3'h2, 13'h0055);
        wait_cmd();
        u_ddr3_host_model.pins(1'b0, 1'b1, 1'b1);
        tick(5);
        check({active_pd, clocks_on, pd_buffers_on}, 3'h4);
        u_ddr3_host_model.issue(1'b0, `CMD_ACT, 3'h6, 13'h0001);
        wait_cmd();
        check(bank_open[6], 1'b0);
        u_ddr3_host_model.pins(1'b1, 1'b1, 1'b1);
        tick(5);
        check({active_pd, clocks_on}, 2'h1);
        u_ddr3_host_model.issue(1'b0, `CMD_PRE, 3'h0, 13'h0400);
        wait_cmd();
        check({cmd.all_banks, bank_open}, 9'h100);
    endtask : t_pd
    task automatic t_sr();
        u_ddr3_host_model.pins(1'b0, 1'b1, 1'b1);
        tick(5);
        check({sr_active, active_pd, pd_buffers_on, term_on}, 4'h1);
        u_ddr3_host_model.pins(1'b1, 1'b1, 1'b1);
        tick(5);
        check(pd_buffers_on, 1'b1);
        u_ddr3_host_model.sr_enter();
        tick(5);
        check({sr_active, term_on, clocks_on}, 3'h4);
        u_ddr3_host_model.pins(1'b1, 1'b1, 1'b1);
        tick(5);
        check(sr_active, 1'b0);
    endtask : t_sr
    task automatic t_reset();
        u_ddr3_host_model.issue(1'b0, `CMD_ACT, 3'h7, 13'h0002);
        u_ddr3_host_model.pins(1'b1, 1'b0, 1'b0);
        tick(3);
        check({in_reset, bank_open}, 9'h100);
        u_ddr3_host_model.pins(1'b1, 1'b0, 1'b1);
        tick(4);
        check(in_reset, 1'b0);
    endtask : t_reset
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        tick(4);
        t_act_rw();
        t_mask();
        t_beat();
        t_mode_term();
        t_pd();
        t_sr();
        t_reset();
        stop_test();
    end
endmodule : test_ddr3_ca_frontend
